// [rtl/tcc_pkg.sv]
// Package for the 16-bit timer counter with input capture
package tcc_pkg;

  // I/O location offsets on the 8-bit data bus
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFF_CTRL_A = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL_B = 6'h01;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LOW = 6'h02;
  localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH = 6'h03;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_LOW = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_HIGH = 6'h05;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 6'h06;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 6'h07;

  // Field positions
  localparam int CTRLA_WGM_LO = 0;    // waveform_mode_field[1:0] at [1:0]
  localparam int CTRLB_CS_LO = 0;     // clock_select_field at [2:0]
  localparam int CTRLB_WGM_HI = 3;    // waveform_mode_field[3:2] at [4:3]
  localparam int CTRLB_EDGE = 6;      // 1 = rising edge triggers capture
  localparam int CTRLB_NOISE = 7;     // noise_filter_enable
  localparam int FLAG_OVF = 0;        // overflow_flag / its enable
  localparam int FLAG_CAP = 5;        // capture_flag / capture_irq_enable

  // Values after reset
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CAPTURE_RST = 16'h0000;

  // Counter limits
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [2:0] CS_STOPPED = 3'h0;

  // Noise canceler depth in system clock samples
  localparam int NOISE_SAMPLES = 4;

  // Processor access carried as one bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } tcc_io_req_t;

endpackage

// [rtl/tcc_timer16.sv]
// 16-bit up/down timer counter with input capture unit and 8-bit register access
`timescale 1ns/10ps

module tcc_timer16 (
  input wire logic core_clk,
  input wire logic arst_n,
  input tcc_pkg::tcc_io_req_t io_req,
  output logic [7:0] io_rdata,
  input wire logic timer_tick,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic comparator_capture_select,
  input wire logic [15:0] compare_a_top,
  input wire logic capture_irq_ack,
  input wire logic overflow_irq_ack,
  output logic capture_irq,
  output logic overflow_irq,
  output logic [15:0] count_value,
  output logic count_down,
  output logic top_hit,
  output logic bottom_hit
);
  import tcc_pkg::*;

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] mask_reg;
  logic [7:0] temp_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] capture_reg;
  logic dir_down_reg;
  logic dir_down_next;
  logic ovf_flag_reg;
  logic cap_flag_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic [NOISE_SAMPLES-2:0] sample_reg;
  logic [NOISE_SAMPLES-1:0] filt_window;
  logic filt_reg;
  logic edge_prev_reg;
  logic [3:0] wgm;
  logic [15:0] top_val;
  logic tick_en;
  logic wr_count_low;
  logic wr_capture_low;
  logic trig_src;
  logic edge_in;
  logic edge_hit;
  logic capture_evt;
  logic ovf_evt;
  logic at_top;
  logic at_bottom;
  logic wr_high_byte;
  logic rd_count_low;
  logic rd_capture_low;
  logic clr_ovf_wr;
  logic clr_cap_wr;

  // Modes whose top value comes from the capture register
  function automatic logic mode_icr_top(input logic [3:0] m);
    return (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
  endfunction

  // Dual-slope modes turn around at top and bottom
  function automatic logic mode_dual(input logic [3:0] m);
    return ((m >= 4'h1) && (m <= 4'h3)) || ((m >= 4'h8) && (m <= 4'hB));
  endfunction

  // Clear-on-match modes flag overflow at maximum, not at top
  function automatic logic mode_ctc(input logic [3:0] m);
    return (m == 4'h4) || (m == 4'hC);
  endfunction

  // Top value per mode
  function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] icr,
                                           input logic [15:0] ocra);
    case (m)
      4'h1, 4'h5: return TOP_8BIT;
      4'h2, 4'h6: return TOP_9BIT;
      4'h3, 4'h7: return TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: return ocra;
      4'h8, 4'hA, 4'hC, 4'hE: return icr;
      default: return COUNT_MAX;
    endcase
  endfunction

  // One access of the given kind to one location
  function automatic logic bus_hit(input tcc_io_req_t r, input logic is_wr,
                                   input logic [ADDR_W-1:0] a);
    return (is_wr ? r.wr : r.rd) && (r.addr == a);
  endfunction

  // Mode field split across both control registers
  assign wgm = {ctrl_b_reg[CTRLB_WGM_HI+1:CTRLB_WGM_HI],
                ctrl_a_reg[CTRLA_WGM_LO+1:CTRLA_WGM_LO]};
  assign top_val = mode_top(wgm, capture_reg, compare_a_top);
  // Prescaler outside delivers the tick; a stopped select masks it
  assign tick_en = timer_tick && (ctrl_b_reg[CTRLB_CS_LO+2:CTRLB_CS_LO] != CS_STOPPED);
  assign at_top = (count_reg == top_val);
  assign at_bottom = (count_reg == 16'h0000);

  // Low-byte writes commit the whole 16-bit word
  assign wr_count_low = bus_hit(io_req, 1'b1, OFF_COUNT_LOW);
  assign wr_capture_low = bus_hit(io_req, 1'b1, OFF_CAPTURE_LOW)
                          && mode_icr_top(wgm);
  // Either high location loads the shared latch; low reads refill it
  assign wr_high_byte = bus_hit(io_req, 1'b1, OFF_COUNT_HIGH) ||
                        bus_hit(io_req, 1'b1, OFF_CAPTURE_HIGH);
  assign rd_count_low = bus_hit(io_req, 1'b0, OFF_COUNT_LOW);
  assign rd_capture_low = bus_hit(io_req, 1'b0, OFF_CAPTURE_LOW);
  // Flag writes only clear, and only where a one is written
  assign clr_ovf_wr = bus_hit(io_req, 1'b1, OFF_FLAGS) && io_req.wdata[FLAG_OVF];
  assign clr_cap_wr = bus_hit(io_req, 1'b1, OFF_FLAGS) && io_req.wdata[FLAG_CAP];

  // Control and mask registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a_reg <= CTRL_A_RST;
      ctrl_b_reg <= CTRL_B_RST;
      mask_reg <= MASK_RST;
    end else if (io_req.wr) begin
      case (io_req.addr)
        OFF_CTRL_A: ctrl_a_reg <= io_req.wdata;
        OFF_CTRL_B: ctrl_b_reg <= io_req.wdata;
        OFF_IRQ_MASK: mask_reg <= io_req.wdata;
        default: ;
      endcase
    end
  end

  // Shared high-byte latch for both 16-bit registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_reg <= 8'h00;
    end else if (wr_high_byte) begin
      temp_reg <= io_req.wdata;
    end else if (rd_count_low) begin
      temp_reg <= count_reg[15:8];
    end else if (rd_capture_low) begin
      temp_reg <= capture_reg[15:8];
    end
  end

  // Next count and direction per mode
  always_comb begin
    count_next = count_reg;
    dir_down_next = dir_down_reg;
    if (wr_count_low) begin
      // Write wins over any tick, stopped or not
      count_next = {temp_reg, io_req.wdata};
    end else if (tick_en) begin
      if (mode_dual(wgm)) begin
        // Turn round going up at top and going down at zero
        if (!dir_down_reg && at_top) begin
          dir_down_next = 1'b1;
          count_next = count_reg - 16'h0001;
        end else if (dir_down_reg && at_bottom) begin
          dir_down_next = 1'b0;
          count_next = count_reg + 16'h0001;
        end else if (dir_down_reg) begin
          count_next = count_reg - 16'h0001;
        end else begin
          count_next = count_reg + 16'h0001;
        end
      end else begin
        // Single slope always counts up; a left-over down state is dropped
        dir_down_next = 1'b0;
        if (at_top) begin
          count_next = COUNT_RST;
        end else begin
          count_next = count_reg + 16'h0001;
        end
      end
    end
  end

  // Counter and direction state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= COUNT_RST;
      dir_down_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      dir_down_reg <= dir_down_next;
    end
  end

  // Overflow point: bottom in dual slope, max in clear-on-match, else top
  always_comb begin
    if (mode_dual(wgm)) begin
      ovf_evt = tick_en && dir_down_reg && at_bottom;
    end else if (mode_ctc(wgm)) begin
      ovf_evt = tick_en && (count_reg == COUNT_MAX);
    end else begin
      ovf_evt = tick_en && at_top;
    end
  end

  // Overflow flag; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_flag_reg <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_reg <= 1'b1;
    end else if (overflow_irq_ack || clr_ovf_wr) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_reg <= 2'b00;
      cmp_sync_reg <= 2'b00;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], capture_pin};
      cmp_sync_reg <= {cmp_sync_reg[0], comparator_output};
    end
  end

  // Source switch can itself look like an edge
  assign trig_src = comparator_capture_select ? cmp_sync_reg[1] : pin_sync_reg[1];

  // Window holds the live level too, so the filter costs four cycles, not five
  assign filt_window = {sample_reg, trig_src};

  // Noise canceler on system clock, independent of the prescaler
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_reg <= '0;
      filt_reg <= 1'b0;
    end else begin
      sample_reg <= {sample_reg[NOISE_SAMPLES-3:0], trig_src};
      if (&filt_window) begin
        filt_reg <= 1'b1;
      end else if (~|filt_window) begin
        filt_reg <= 1'b0;
      end
    end
  end

  // Edge detector input, filtered or direct
  assign edge_in = ctrl_b_reg[CTRLB_NOISE] ? filt_reg : trig_src;

  // Edge history resets to the synchroniser level, so reset makes no edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_prev_reg <= 1'b0;
    end else begin
      edge_prev_reg <= edge_in;
    end
  end

  // Sense the edge chosen in control B; inputs idle while capture defines top
  assign edge_hit = ctrl_b_reg[CTRLB_EDGE] ? (edge_in && !edge_prev_reg)
                                           : (!edge_in && edge_prev_reg);
  assign capture_evt = edge_hit && !mode_icr_top(wgm);

  // Capture register: events overwrite unread data, writes only in top modes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_reg <= CAPTURE_RST;
    end else if (capture_evt) begin
      capture_reg <= count_reg;
    // Never both at once: writes need a top mode, which idles the input
    end else if (wr_capture_low) begin
      capture_reg <= {temp_reg, io_req.wdata};
    end
  end

  // Capture flag; set wins over write-one clear and service clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_flag_reg <= 1'b0;
    end else if (capture_evt) begin
      cap_flag_reg <= 1'b1;
    end else if (capture_irq_ack) begin
      cap_flag_reg <= 1'b0;
    end else if (clr_cap_wr) begin
      cap_flag_reg <= 1'b0;
    end
  end

  // Read data registered; high locations return the latch, not live bits
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata <= 8'h00;
    end else if (io_req.rd) begin
      case (io_req.addr)
        OFF_CTRL_A: io_rdata <= ctrl_a_reg;
        OFF_CTRL_B: io_rdata <= ctrl_b_reg;
        OFF_COUNT_LOW: io_rdata <= count_reg[7:0];
        OFF_COUNT_HIGH: io_rdata <= temp_reg;
        OFF_CAPTURE_LOW: io_rdata <= capture_reg[7:0];
        OFF_CAPTURE_HIGH: io_rdata <= temp_reg;
        // Flag byte built from the two flag positions
        OFF_FLAGS: io_rdata <= 8'(({7'h00, cap_flag_reg} << FLAG_CAP) |
                                  ({7'h00, ovf_flag_reg} << FLAG_OVF));
        OFF_IRQ_MASK: io_rdata <= mask_reg;
        default: io_rdata <= 8'h00;
      endcase
    end
  end

  // Requests held while flag and enable both set
  assign capture_irq = cap_flag_reg && mask_reg[FLAG_CAP];
  assign overflow_irq = ovf_flag_reg && mask_reg[FLAG_OVF];

  // Status toward compare and waveform units
  assign count_value = count_reg;
  assign count_down = dir_down_reg;
  assign top_hit = at_top;
  assign bottom_hit = at_bottom;

endmodule

// [verification/tcc_timer16_asserts.sv]
// Port checker for the 16-bit timer counter
`timescale 1ns/10ps
module tcc_timer16_asserts (
  input wire logic core_clk,
  input wire logic arst_n,
  input tcc_pkg::tcc_io_req_t io_req,
  input wire logic [7:0] io_rdata,
  input wire logic timer_tick,
  input wire logic capture_irq_ack,
  input wire logic overflow_irq_ack,
  input wire logic capture_irq,
  input wire logic overflow_irq,
  input wire logic [15:0] count_value,
  input wire logic bottom_hit
);
  import tcc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Count and read-back relations
  bottom_zero_a: assert property (bottom_hit == (count_value == 16'h0000))
    else $error("bottom flag wrong");
  count_hold_a: assert property (!timer_tick && !io_req.wr |=> $stable(count_value))
    else $error("count moved with no tick or write");
  low_write_a: assert property (io_req.wr && io_req.addr == OFF_COUNT_LOW
    |=> count_value[7:0] == $past(io_req.wdata)) else $error("count low write lost");
  read_low_a: assert property (io_req.rd && io_req.addr == OFF_COUNT_LOW
    |=> io_rdata == $past(count_value[7:0])) else $error("count low read wrong");
  read_high_a: assert property (io_req.rd && io_req.addr == OFF_COUNT_LOW ##1
    io_req.rd && io_req.addr == OFF_COUNT_HIGH |=> io_rdata == $past(count_value[15:8], 2))
    else $error("count high read not latched");
  rdata_hold_a: assert property (!io_req.rd |=> $stable(io_rdata))
    else $error("read data changed without read");
  // Interrupt lines drop only by service or a register write
  cap_irq_a: assert property (capture_irq |=> capture_irq || $past(capture_irq_ack)
    || $past(io_req.wr)) else $error("capture request dropped");
  ovf_irq_a: assert property (overflow_irq |=> overflow_irq || $past(overflow_irq_ack)
    || $past(io_req.wr)) else $error("overflow request dropped");
  cap_seen_c: cover property ($rose(capture_irq));
  ovf_seen_c: cover property ($rose(overflow_irq));
  wrap_seen_c: cover property (count_value == 16'hFFFF ##1 count_value == 16'h0000);
endmodule
bind tcc_timer16 tcc_timer16_asserts u_chk (
  .core_clk(core_clk),
  .arst_n(arst_n),
  .io_req(io_req),
  .io_rdata(io_rdata),
  .timer_tick(timer_tick),
  .capture_irq_ack(capture_irq_ack),
  .overflow_irq_ack(overflow_irq_ack),
  .capture_irq(capture_irq),
  .overflow_irq(overflow_irq),
  .count_value(count_value),
  .bottom_hit(bottom_hit)
);

// [verification/tcc_cpu_model.sv]
// Processor core model on the 8-bit register bus
`timescale 1ns/10ps
module tcc_cpu_model (
  input wire logic core_clk,
  output tcc_pkg::tcc_io_req_t io_req
);
  import tcc_pkg::*;
  logic [7:0] exp_q[$];
  // Requests change at falling edges; each lasts one full cycle
  initial io_req = '0;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_req <= {1'b1, 1'b0, a, d};
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    io_req <= {1'b0, 1'b1, a, ~io_req.wdata};
    @(negedge core_clk);
  endtask
  // Idle data toggles so a stale byte never looks valid
  task automatic idle(input int n);
    io_req <= {2'b00, io_req.addr, ~io_req.wdata};
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr(a + 6'h01, d[15:8]);
    wr(a, d[7:0]);
  endtask
  task automatic rd16(input logic [5:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a + 6'h01, e[15:8]);
  endtask
endmodule

// [verification/tcc_timer16_tb_top.sv]
// Self-checking bench for the 16-bit timer counter
`timescale 1ns/10ps
module tcc_timer16_tb_top;
  import tcc_pkg::*;
  logic core_clk, arst_n, timer_tick, capture_pin, comparator_output, comparator_capture_select;
  logic capture_irq_ack, overflow_irq_ack, capture_irq, overflow_irq, count_down;
  logic top_hit, bottom_hit, taken;
  logic [15:0] count_value, v, top_a;
  logic [7:0] io_rdata, e;
  tcc_io_req_t io_req;
  int n_fail, n_tests, seed;
  tcc_cpu_model u_cpu (.core_clk(core_clk), .io_req(io_req));
  tcc_timer16 u_tcc_timer16 (.core_clk(core_clk), .arst_n(arst_n), .io_req(io_req),
    .io_rdata(io_rdata), .timer_tick(timer_tick), .capture_pin(capture_pin),
    .comparator_output(comparator_output), .comparator_capture_select(comparator_capture_select),
    .compare_a_top(top_a), .capture_irq_ack(capture_irq_ack),
    .overflow_irq_ack(overflow_irq_ack), .capture_irq(capture_irq), .overflow_irq(overflow_irq),
    .count_value(count_value), .count_down(count_down), .top_hit(top_hit),
    .bottom_hit(bottom_hit));
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
    n_tests++;
    if (x !== s) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  // Read answer lands at the taking edge and is checked at the next falling edge; oldest note first
  always @(posedge core_clk) taken <= io_req.rd;
  always @(negedge core_clk) if (taken) begin
    e = u_cpu.exp_q.pop_front();
    chk("io_rdata", e, io_rdata);
  end
  initial begin
    seed = 32'hf3d8;
    top_a = {1'b0, 15'($random(seed))};
    arst_n = 1'b0;
    timer_tick = 1'b1;
    capture_pin = 1'b0;
    comparator_output = 1'b0;
    comparator_capture_select = 1'b0;
    capture_irq_ack = 1'b0;
    overflow_irq_ack = 1'b0;
    repeat (6) @(negedge core_clk);
    arst_n = 1'b1;
    // Reset contents, unmapped place, then stopped counter still ticked
    for (int i = 0; i < 8; i++) u_cpu.rd(6'(i), 8'h00);
    u_cpu.rd(6'h3F, 8'h00);
    u_cpu.wr16(OFF_COUNT_LOW, 16'h1234);
    u_cpu.idle(4);
    u_cpu.rd16(OFF_COUNT_LOW, 16'h1234);
    repeat (4) begin
      v = 16'($random(seed));
      timer_tick = 1'($random(seed));
      u_cpu.wr16(OFF_COUNT_LOW, v);
      u_cpu.rd16(OFF_COUNT_LOW, v);
    end
    // Mode 0 wrap raises overflow; service clears it
    timer_tick = 1'b0;
    u_cpu.wr(OFF_CTRL_B, 8'h01);
    u_cpu.wr(OFF_IRQ_MASK, 8'h21);
    u_cpu.wr16(OFF_COUNT_LOW, 16'hFFFE);
    timer_tick = 1'b1;
    u_cpu.idle(2);
    timer_tick = 1'b0;
    u_cpu.rd16(OFF_COUNT_LOW, 16'h0000);
    u_cpu.rd(OFF_FLAGS, 8'h01);
    chk("overflow_irq", 8'h01, {7'h00, overflow_irq});
    overflow_irq_ack = 1'b1;
    u_cpu.idle(1);
    overflow_irq_ack = 1'b0;
    chk("overflow_irq", 8'h00, {7'h00, overflow_irq});
    // Mode 4 clears at compare top; mode 1 turns round at both ends
    u_cpu.wr(OFF_CTRL_B, 8'h09);
    u_cpu.wr16(OFF_COUNT_LOW, top_a);
    chk("top_hit", 8'h01, {7'h00, top_hit});
    timer_tick = 1'b1;
    u_cpu.idle(1);
    timer_tick = 1'b0;
    chk("bottom_hit", 8'h01, {7'h00, bottom_hit});
    u_cpu.rd(OFF_FLAGS, 8'h00);
    u_cpu.wr(OFF_CTRL_A, 8'h01);
    u_cpu.wr(OFF_CTRL_B, 8'h01);
    u_cpu.wr16(OFF_COUNT_LOW, 16'h00FF);
    timer_tick = 1'b1;
    u_cpu.idle(1);
    timer_tick = 1'b0;
    chk("count_down", 8'h01, {7'h00, count_down});
    u_cpu.wr16(OFF_COUNT_LOW, 16'h0001);
    timer_tick = 1'b1;
    u_cpu.idle(2);
    timer_tick = 1'b0;
    chk("count_down", 8'h00, {7'h00, count_down});
    u_cpu.rd16(OFF_COUNT_LOW, 16'h0001);
    u_cpu.rd(OFF_FLAGS, 8'h01);
    u_cpu.wr(OFF_FLAGS, 8'h01);
    u_cpu.wr(OFF_CTRL_A, 8'h00);
    // Write lands while the counter is ticking
    timer_tick = 1'b1;
    u_cpu.wr16(OFF_COUNT_LOW, 16'h55AA);
    timer_tick = 1'b0;
    u_cpu.wr(OFF_CTRL_B, 8'h40);
    u_cpu.rd16(OFF_COUNT_LOW, 16'h55AA);
    // Rising pin edge captures the stopped count
    capture_pin = 1'b1;
    u_cpu.idle(8);
    chk("capture_irq", 8'h01, {7'h00, capture_irq});
    u_cpu.rd16(OFF_CAPTURE_LOW, 16'h55AA);
    u_cpu.wr(OFF_FLAGS, 8'h00);
    u_cpu.rd(OFF_FLAGS, 8'h20);
    u_cpu.wr(OFF_FLAGS, 8'h20);
    capture_pin = 1'b0;
    u_cpu.idle(8);
    u_cpu.rd(OFF_FLAGS, 8'h00);
    // Filtered: short glitch ignored, held level captured late
    u_cpu.wr(OFF_CTRL_B, 8'hC0);
    u_cpu.wr16(OFF_COUNT_LOW, 16'h0C0D);
    capture_pin = 1'b1;
    u_cpu.idle(3);
    capture_pin = 1'b0;
    u_cpu.idle(12);
    u_cpu.rd(OFF_FLAGS, 8'h00);
    capture_pin = 1'b1;
    u_cpu.idle(5);
    u_cpu.rd(OFF_FLAGS, 8'h00);
    u_cpu.idle(8);
    u_cpu.rd16(OFF_CAPTURE_LOW, 16'h0C0D);
    capture_irq_ack = 1'b1;
    u_cpu.idle(1);
    capture_irq_ack = 1'b0;
    chk("capture_irq", 8'h00, {7'h00, capture_irq});
    // Comparator as trigger; clear flag after switching source
    comparator_capture_select = 1'b1;
    u_cpu.idle(12);
    u_cpu.wr(OFF_FLAGS, 8'h20);
    comparator_output = 1'b1;
    u_cpu.idle(14);
    u_cpu.rd(OFF_FLAGS, 8'h20);
    // Capture writes refused in mode 0, taken in mode 12 where input is off
    u_cpu.wr16(OFF_CAPTURE_LOW, 16'h1234);
    u_cpu.rd16(OFF_CAPTURE_LOW, 16'h0C0D);
    u_cpu.wr(OFF_CTRL_B, 8'h80);
    u_cpu.wr(OFF_FLAGS, 8'h20);
    u_cpu.rd(OFF_FLAGS, 8'h00);
    u_cpu.wr(OFF_CTRL_B, 8'h18);
    u_cpu.wr16(OFF_CAPTURE_LOW, 16'h1234);
    comparator_output = 1'b0;
    u_cpu.idle(14);
    u_cpu.rd16(OFF_CAPTURE_LOW, 16'h1234);
    u_cpu.idle(2);
    conclude();
  end
endmodule
